// file: verilog/ews_pkg.sv
// Shared constants, types and decode helpers for the serial EEPROM core
package ews_pkg;

  // ****************************************************
  // Clock and programming time
  // ****************************************************
  localparam int CLK_PERIOD_NS = 4; // Core clock period, 250 MHz
  localparam int WP_TIME_NS = 5000000; // Longest programming time, 5 ms
  // Longest time, so the division rounds down
  localparam int WP_CYCLES = WP_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************
  // Array and buffer sizes
  // ****************************************************
  localparam int CAP_BITS = 4096; // Array capacity in bits
  localparam int FIFO_DEPTH = 16; // Queued programming commands

  // ****************************************************
  // Instruction encoding
  // ****************************************************
  localparam logic [1:0] OP_READ = 2'h2; // Read one or more words
  localparam logic [1:0] OP_WRITE = 2'h1; // Write one word
  localparam logic [1:0] OP_ERASE = 2'h3; // Erase one word
  localparam logic [1:0] OP_EXT = 2'h0; // Sub-code in top address bits
  localparam logic [1:0] EXT_ENABLE = 2'h3; // program_enable_cmd
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2; // erase_all_cmd
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1; // write_all_cmd
  localparam logic [1:0] EXT_DISABLE = 2'h0; // program_disable_cmd

  // ****************************************************
  // Field lengths and reset values
  // ****************************************************
  localparam logic [4:0] OP_LAST = 5'h01; // Index of last opcode bit
  localparam logic [4:0] ABITS_X8 = 5'h09; // Address bits, byte mode
  localparam logic [4:0] ABITS_X16 = 5'h08; // Address bits, word mode
  localparam logic [4:0] DBITS_X8 = 5'h08; // Data bits, byte mode
  localparam logic [4:0] DBITS_X16 = 5'h10; // Data bits, word mode
  localparam logic [15:0] ERASED_WORD = 16'hFFFF; // Erased cell value
  localparam logic PROG_EN_RST = 1'h0; // Programming disabled at reset

  // ****************************************************
  // Types
  // ****************************************************
  // One-hot sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_SKIP = 6'h20
  } ews_fsm_t;

  // Serial link pins as seen by the device
  typedef struct packed {
    logic chip_select;
    logic shift_clock;
    logic serial_in;
    logic word_width_select;
  } ews_pins_t;

  // One queued programming command
  typedef struct packed {
    logic all; // Apply to every word
    logic x16; // Word mode when taken
    logic [8:0] addr; // Word or byte address
    logic [15:0] data; // Value to store
  } ews_cmd_t;

  // Address length for the chosen width
  function automatic logic [4:0] ews_abits(input logic x16);
    ews_abits = x16 ? ABITS_X16 : ABITS_X8;
  endfunction

  // Data length for the chosen width
  function automatic logic [4:0] ews_dbits(input logic x16);
    ews_dbits = x16 ? DBITS_X16 : DBITS_X8;
  endfunction

endpackage

// file: verilog/ews_fifo.sv
// Small valid/ready FIFO for queued programming commands
`timescale 1ns/1ps
module ews_fifo #(
  parameter int WIDTH = 27, // Word width
  parameter int DEPTH = 16 // Number of words
) (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word waiting
  input wire logic out_ready, // Drain takes word
  output logic [WIDTH-1:0] out_data // Oldest word
);

  localparam int PW = $clog2(DEPTH); // Pointer width
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH); // Count when full
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1); // Last slot

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
    logic [PW-1:0] wp; // Write slot
    logic [PW-1:0] rp; // Read slot
    logic [PW:0] cnt; // Words held
  } ews_fifo_state_t;

  ews_fifo_state_t r_reg; // Registered state
  ews_fifo_state_t r_next; // Next state
  logic do_in; // Word accepted
  logic do_out; // Word removed

  // Flags straight from the count
  assign in_ready = (r_reg.cnt != FULL);
  assign out_valid = (r_reg.cnt != '0);
  assign out_data = r_reg.mem[r_reg.rp];

  // Pointer and count update
  always_comb begin
    r_next = r_reg;
    do_in = in_valid & in_ready;
    do_out = out_valid & out_ready;
    if (do_in) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = (r_reg.wp == LAST) ? '0 : r_reg.wp + 1'b1;
    end
    if (do_out) begin
      r_next.rp = (r_reg.rp == LAST) ? '0 : r_reg.rp + 1'b1;
    end
    case ({do_in, do_out})
      2'h2: r_next.cnt = r_reg.cnt + 1'b1;
      2'h1: r_next.cnt = r_reg.cnt - 1'b1;
      default: r_next.cnt = r_reg.cnt;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// file: verilog/ews_core.sv
// Three-wire serial EEPROM device core with self-timed programming
`timescale 1ns/1ps
module ews_core #(
  parameter int WP_CYCLES = ews_pkg::WP_CYCLES, // Programming cycles
  parameter int CAP_BITS = ews_pkg::CAP_BITS, // Array size in bits
  parameter int FIFO_DEPTH = ews_pkg::FIFO_DEPTH // Queued commands
) (
  input wire logic mclk, // Core clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire ews_pkg::ews_pins_t pins, // Raw link pins
  output logic serial_out, // Serial data out level
  output logic serial_out_oe // High while serial out is driven
);
  import ews_pkg::*;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int WORDS = CAP_BITS / 16; // 16-bit storage rows
  localparam int WA = $clog2(WORDS); // Row index width
  localparam int TW = $clog2(WP_CYCLES + 1); // Timer width
  localparam logic [8:0] ROWS = 9'(WORDS); // Rows for write-all
  localparam logic [TW-1:0] WP_LOAD = TW'(WP_CYCLES - 1); // Timer start

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [2:0][3:0] sync; // Pin synchroniser stages
    ews_pins_t stab; // Pins after agreement filter
    ews_fsm_t fsm; // Instruction sequencer
    logic [4:0] cnt; // Bit counter in field
    logic [1:0] op; // Opcode
    logic [8:0] addr; // Address field
    logic [15:0] data; // Data field
    logic x16; // Width taken at start bit
    logic prog_en; // Programming enabled
    logic arm; // Status output armed
    logic sdo; // Serial out level
    logic sdo_oe; // Serial out enable
    logic pg_active; // Programming cycle running
    logic [TW-1:0] pg_left; // Cycles left
    logic [8:0] pg_idx; // Row walker for write-all
    ews_cmd_t pg_cmd; // Command being programmed
  } ews_state_t;

  ews_state_t r_reg; // Registered state
  ews_state_t r_next; // Next state
  logic [3:0] dif; // Stage two and three disagree
  logic sck_rise; // Filtered shift clock rising, selected
  logic [8:0] a_next; // Address after this bit
  logic [1:0] top; // Sub-code bits
  logic push; // Offer command to queue
  ews_cmd_t push_cmd; // Command offered
  logic fifo_ready; // Queue has room
  logic fifo_valid; // Queue holds a command
  ews_cmd_t fifo_cmd; // Oldest queued command
  logic pop; // Engine takes command
  logic busy; // Programming pending or running
  logic mem_we; // Array write this cycle
  logic [WA-1:0] widx; // Array write row
  logic [1:0] wlane; // Byte lanes written
  logic [15:0] wdata; // Array write value
  logic [WA-1:0] ridx; // Array read row
  logic [15:0] rdata_reg; // Registered array read
  logic [3:0] bidx; // Bit of read row to send
  logic rd_bit; // Next read data bit
  logic [15:0] mem [WORDS]; // Nonvolatile array

  // ****************************************************
  // Command queue between sequencer and engine
  // ****************************************************
  ews_fifo #(
    .WIDTH($bits(ews_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_cmd),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_cmd)
  );

  // Busy until the queue drains and the last cycle ends
  assign busy = r_reg.pg_active | fifo_valid;

  // Read bit: word mode or even byte uses the upper lane
  assign bidx = (r_reg.x16 | ~r_reg.addr[0]) ? 4'(15 - r_reg.cnt)
                                              : 4'(7 - r_reg.cnt);
  assign rd_bit = rdata_reg[bidx];

  // ****************************************************
  // Sequencer and programming engine
  // ****************************************************
  always_comb begin
    r_next = r_reg;
    push = 1'b0;
    push_cmd = '0;
    pop = 1'b0;
    top = 2'h0;
    // Three stages; a change counts once two and three agree
    r_next.sync = {r_reg.sync[1], r_reg.sync[0], pins};
    dif = r_reg.sync[2] ^ r_reg.sync[1];
    r_next.stab = ews_pins_t'((r_reg.sync[2] & ~dif) | (r_reg.stab & dif));
    sck_rise = r_next.stab.shift_clock & ~r_reg.stab.shift_clock
             & r_next.stab.chip_select;
    // Word mode keeps eight address bits
    a_next = {r_reg.x16 ? 1'b0 : r_reg.addr[7], r_reg.addr[6:0],
              r_next.stab.serial_in};
    if (!r_next.stab.chip_select) begin
      // Deselected: abort and release the line
      r_next.fsm = ST_IDLE;
      r_next.cnt = '0;
      r_next.sdo_oe = 1'b0;
    end else if (sck_rise) begin
      case (r_reg.fsm)
        ST_IDLE: begin
          // Leading zeros ignored until the start bit
          if (r_next.stab.serial_in) begin
            r_next.fsm = ST_CMD;
            r_next.cnt = '0;
            r_next.arm = 1'b0;
            r_next.sdo_oe = 1'b0;
            // Open pad reads high through its pull-up
            r_next.x16 = r_next.stab.word_width_select;
          end
        end
        ST_CMD: begin
          r_next.op = {r_reg.op[0], r_next.stab.serial_in};
          r_next.cnt = r_reg.cnt + 1'b1;
          if (r_reg.cnt == OP_LAST) begin
            r_next.fsm = ST_ADDR;
            r_next.cnt = '0;
          end
        end
        ST_ADDR: begin
          r_next.addr = a_next;
          r_next.cnt = r_reg.cnt + 1'b1;
          if (r_reg.cnt == ews_abits(r_reg.x16) - 5'h01) begin
            r_next.cnt = '0;
            r_next.fsm = ST_SKIP;
            top = r_reg.x16 ? a_next[7:6] : a_next[8:7];
            push_cmd = '{all: 1'b0, x16: r_reg.x16, addr: a_next,
                         data: ERASED_WORD};
            case (r_reg.op)
              OP_READ: begin
                // Dummy zero precedes the data
                r_next.fsm = ST_READ;
                r_next.sdo = 1'b0;
                r_next.sdo_oe = 1'b1;
              end
              OP_WRITE: r_next.fsm = ST_DATA;
              OP_ERASE: push = r_reg.prog_en;
              default: begin
                case (top)
                  EXT_ENABLE: r_next.prog_en = 1'b1;
                  EXT_DISABLE: r_next.prog_en = 1'b0;
                  EXT_WRITE_ALL: r_next.fsm = ST_DATA;
                  default: begin
                    push_cmd.all = 1'b1;
                    push = r_reg.prog_en;
                  end
                endcase
              end
            endcase
          end
        end
        ST_DATA: begin
          // Most significant data bit first
          r_next.data = {r_reg.data[14:0], r_next.stab.serial_in};
          r_next.cnt = r_reg.cnt + 1'b1;
          if (r_reg.cnt == ews_dbits(r_reg.x16) - 5'h01) begin
            r_next.fsm = ST_SKIP;
            push_cmd = '{all: r_reg.op == OP_EXT, x16: r_reg.x16,
                         addr: r_reg.addr, data: r_next.data};
            push = r_reg.prog_en;
          end
        end
        ST_READ: begin
          // One bit per shift clock, then on to the next word
          r_next.sdo = rd_bit;
          r_next.cnt = r_reg.cnt + 1'b1;
          if (r_reg.cnt == ews_dbits(r_reg.x16) - 5'h01) begin
            r_next.cnt = '0;
            r_next.addr = r_reg.x16 ? {1'b0, 8'(r_reg.addr[7:0] + 1'b1)}
                                    : r_reg.addr + 1'b1;
          end
        end
        ST_SKIP: r_next.fsm = ST_SKIP; // Surplus bits ignored
        default: r_next.fsm = ST_IDLE;
      endcase
    end
    // A full queue refuses the command; it is dropped
    if (push && fifo_ready) begin
      r_next.arm = 1'b1;
    end
    // Status on serial out while selected, idle and armed
    if (r_next.fsm == ST_IDLE && r_next.stab.chip_select
        && r_next.arm) begin
      r_next.sdo_oe = 1'b1;
      r_next.sdo = ~busy;
    end
    // Engine: one command per timed cycle, no shift clock needed
    if (!r_reg.pg_active) begin
      if (fifo_valid) begin
        pop = 1'b1;
        r_next.pg_active = 1'b1;
        r_next.pg_cmd = fifo_cmd;
        r_next.pg_left = WP_LOAD;
        r_next.pg_idx = '0;
      end
    end else begin
      if (r_reg.pg_idx != ROWS) begin
        r_next.pg_idx = r_reg.pg_idx + 1'b1;
      end
      if (r_reg.pg_left == '0) begin
        r_next.pg_active = 1'b0;
      end else begin
        r_next.pg_left = r_reg.pg_left - 1'b1;
      end
    end
  end

  // ****************************************************
  // Array port decode
  // ****************************************************
  always_comb begin
    // Direct overwrite: the new value replaces the cell
    mem_we = r_reg.pg_active && (r_reg.pg_cmd.all
             ? (r_reg.pg_idx != ROWS) : (r_reg.pg_idx == '0));
    if (r_reg.pg_cmd.all) begin
      widx = r_reg.pg_idx[WA-1:0];
    end else if (r_reg.pg_cmd.x16) begin
      widx = r_reg.pg_cmd.addr[WA-1:0];
    end else begin
      widx = r_reg.pg_cmd.addr[WA:1];
    end
    if (r_reg.pg_cmd.x16 || r_reg.pg_cmd.all) begin
      wlane = 2'h3;
    end else begin
      wlane = r_reg.pg_cmd.addr[0] ? 2'h1 : 2'h2;
    end
    wdata = r_reg.pg_cmd.x16 ? r_reg.pg_cmd.data
          : {r_reg.pg_cmd.data[7:0], r_reg.pg_cmd.data[7:0]};
    ridx = r_reg.x16 ? r_reg.addr[WA-1:0] : r_reg.addr[WA:1];
  end

  // Array storage, not reset; read row registered
  always_ff @(posedge mclk) begin
    if (mem_we && wlane[1]) begin
      mem[widx][15:8] <= wdata[15:8];
    end
    if (mem_we && wlane[0]) begin
      mem[widx][7:0] <= wdata[7:0];
    end
    rdata_reg <= mem[ridx];
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.fsm <= ST_IDLE;
      r_reg.prog_en <= PROG_EN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops
  assign serial_out = r_reg.sdo;
  assign serial_out_oe = r_reg.sdo_oe;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_hiz;
    @(posedge mclk) disable iff (!rst_n)
    !r_reg.stab.chip_select |-> !r_reg.sdo_oe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("serial out driven while deselected");

  property p_status;
    @(posedge mclk) disable iff (!rst_n)
    (r_reg.fsm == ST_IDLE && r_reg.sdo_oe) |-> r_reg.sdo == !$past(busy);
  endproperty
  a_status: assert property (p_status)
    else $error("status level does not match busy");

  property p_gate;
    @(posedge mclk) disable iff (!rst_n)
    push |-> r_reg.prog_en;
  endproperty
  a_gate: assert property (p_gate)
    else $error("programming queued while disabled");

  property p_tstart;
    @(posedge mclk) disable iff (!rst_n)
    pop |=> r_reg.pg_active && r_reg.pg_left == WP_LOAD;
  endproperty
  a_tstart: assert property (p_tstart)
    else $error("programming timer not loaded");

  property p_tend;
    @(posedge mclk) disable iff (!rst_n)
    (r_reg.pg_active && r_reg.pg_left == '0) |=> !r_reg.pg_active;
  endproperty
  a_tend: assert property (p_tend)
    else $error("programming cycle overran");

  property p_direct;
    @(posedge mclk) disable iff (!rst_n)
    pop |=> mem_we;
  endproperty
  a_direct: assert property (p_direct)
    else $error("array not written at cycle start");

  property p_read;
    @(posedge mclk) disable iff (!rst_n)
    (r_reg.fsm == ST_READ && sck_rise)
      |=> r_reg.sdo == $past(rd_bit) && r_reg.sdo_oe;
  endproperty
  a_read: assert property (p_read)
    else $error("read bit not shifted out");

  property p_width;
    @(posedge mclk) disable iff (!rst_n)
    (r_reg.fsm == ST_IDLE && sck_rise && r_next.stab.serial_in)
      |=> r_reg.x16 == $past(r_next.stab.word_width_select);
  endproperty
  a_width: assert property (p_width)
    else $error("word width not taken at start bit");

  property p_lead;
    @(posedge mclk) disable iff (!rst_n)
    (r_reg.fsm == ST_IDLE && sck_rise && !r_next.stab.serial_in)
      |=> r_reg.fsm == ST_IDLE;
  endproperty
  a_lead: assert property (p_lead)
    else $error("zero taken as start bit");

  property p_alen;
    @(posedge mclk) disable iff (!rst_n)
    (r_reg.fsm == ST_ADDR && sck_rise
     && r_reg.cnt == ews_abits(r_reg.x16) - 5'h01)
      |=> r_reg.fsm != ST_ADDR && r_reg.cnt == '0;
  endproperty
  a_alen: assert property (p_alen)
    else $error("address field length wrong");

endmodule

// file: tb/ews_host.sv
// Host model that drives the serial link pins of the device
`timescale 1ns/1ps
module ews_host (
  input wire logic mclk, // Core clock
  input wire logic serial_out, // Device data out
  input wire logic serial_out_oe, // Device drive enable
  output ews_pkg::ews_pins_t pins, // Link pins to the device
  output logic so_wire // Resolved serial out line
);
  import ews_pkg::*;
  localparam int HALF = 8; // Clocks per shift clock phase
  logic [31:0] rx; // Bits seen on serial out
  // ****************************************************
  // Line level and pin start values
  // ****************************************************
  // Undriven line shows the inverse, so a stale level cannot pass
  assign so_wire = serial_out_oe ? serial_out : ~serial_out;
  // Open width pad reads high through its pull-up
  initial begin
    pins = '{1'b0, 1'b0, 1'b0, 1'b1};
  end
  // Wait whole core clocks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Select or deselect; data line scrambles when idle
  task automatic sel(input logic b);
    pins.chip_select <= b;
    if (!b) begin
      pins.serial_in <= ~pins.serial_in;
    end
    wait_clk(HALF);
  endtask
  // Set the word width pad
  task automatic width(input logic b);
    pins.word_width_select <= b;
    wait_clk(HALF);
  endtask
  // Shift n bits MSB first, capture serial out after each rise
  task automatic shift(input int n, input logic [31:0] v);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      pins.serial_in <= v[i];
      wait_clk(HALF);
      pins.shift_clock <= 1'b1;
      wait_clk(HALF);
      rx = {rx[30:0], so_wire};
      pins.shift_clock <= 1'b0;
    end
    wait_clk(HALF);
  endtask
  // One whole instruction between select rise and fall
  task automatic frame(input int n, input logic [31:0] v);
    sel(1'b1);
    shift(n, v);
    sel(1'b0);
  endtask
endmodule

// file: tb/ews_core_test.sv
// Self-checking testbench for the serial EEPROM device core
`timescale 1ns/1ps
module ews_core_test;
  import ews_pkg::*;
  // Shortened programming time; write-all needs one cycle per row
  localparam int WP_SIM = 300;
  localparam logic [10:0] I_EN = 11'h4C0; // program_enable_cmd
  localparam logic [10:0] I_DIS = 11'h400; // program_disable_cmd
  localparam logic [10:0] I_ERASE_ALL_CMD = 11'h480; // erase_all_cmd
  localparam logic [10:0] I_WRITE_ALL_CMD = 11'h440; // write_all_cmd head
  logic mclk = 1'b0; // Core clock
  logic rst_n; // Reset, active low
  ews_pins_t pins; // Link pins
  logic serial_out; // Device data out
  logic serial_out_oe; // Device drive enable
  logic so_wire; // Resolved line
  int fail_count = 0; // Mismatches
  int comparisons = 0; // Checks made
  // ****************************************************
  // Clock, design and host
  // ****************************************************
  always #2 mclk = ~mclk;
  ews_core #(.WP_CYCLES(WP_SIM)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .pins(pins), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  ews_host i_host (.mclk(mclk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .pins(pins), .so_wire(so_wire));
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Program, then watch status: busy, ready in bound, released
  task automatic prog(input int n, input logic [31:0] v);
    int k;
    i_host.frame(n, v);
    i_host.sel(1'b1);
    chk({15'h0, serial_out_oe}, 16'h0001);
    chk({15'h0, so_wire}, 16'h0000);
    k = 0;
    while (so_wire !== 1'b1 && k < 60) begin
      i_host.wait_clk(8);
      k++;
    end
    chk({15'h0, so_wire}, 16'h0001);
    i_host.sel(1'b0);
    chk({15'h0, serial_out_oe}, 16'h0000);
  endtask
  // Read one x16 word
  task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
    i_host.frame(27, {3'b110, a, 16'h0});
    chk({15'h0, i_host.rx[16]}, 16'h0000);
    chk(i_host.rx[15:0], exp);
  endtask
  // Read one x8 byte
  task automatic rd8(input logic [8:0] a, input logic [7:0] exp);
    i_host.frame(20, {3'b110, a, 8'h0});
    chk({15'h0, i_host.rx[8]}, 16'h0000);
    chk({8'h0, i_host.rx[7:0]}, {8'h0, exp});
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  // Line undriven while deselected
  task automatic t_idle;
    chk({15'h0, serial_out_oe}, 16'h0000);
    $display("t_idle done");
  endtask
  // Programming while disabled leaves the word
  task automatic t_gate;
    i_host.frame(11, I_EN);
    prog(11, {3'b111, 8'h05});
    i_host.frame(11, I_DIS);
    i_host.frame(27, {3'b101, 8'h05, 16'h1234});
    i_host.wait_clk(2 * WP_SIM);
    rd16(8'h05, 16'hFFFF);
    $display("t_gate done");
  endtask
  // Write over a written word, no erase between
  task automatic t_over;
    i_host.frame(11, I_EN);
    prog(27, {3'b101, 8'h05, 16'h1234});
    rd16(8'h05, 16'h1234);
    prog(27, {3'b101, 8'h05, 16'h00F0});
    rd16(8'h05, 16'h00F0);
    $display("t_over done");
  endtask
  // Byte lanes of a row in x8 mode
  task automatic t_byte;
    i_host.width(1'b0);
    rd8(9'h00A, 8'h00);
    rd8(9'h00B, 8'hF0);
    prog(20, {3'b101, 9'h00A, 8'h5A});
    i_host.width(1'b1);
    rd16(8'h05, 16'h5AF0);
    $display("t_byte done");
  endtask
  // Whole array erase and fill, erase read back at both ends of the range
  task automatic t_all;
    prog(11, I_ERASE_ALL_CMD);
    rd16(8'h00, 16'hFFFF);
    rd16(8'hFF, 16'hFFFF);
    prog(27, {I_WRITE_ALL_CMD, 16'hC3A5});
    rd16(8'h80, 16'hC3A5);
    $display("t_all done");
  endtask
  // Print counts and the verdict, then stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence after four reset cycles
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    i_host.wait_clk(8);
    t_idle();
    t_gate();
    t_over();
    t_byte();
    t_all();
    end_sim();
  end
  // Watchdog, well past the expected run length
  initial begin
    #200000;
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
